/* btr_pkg.sv */
// constants, types and helpers shared by the buck-boost target and ramp control
// Operation
// R01 - enable under shutdown level: stop, reset every register to default
// R02 - no register access until 100 us after enable rises; host waits
// R03 - enable below high threshold inhibits all switching, supply regardless
// R04 - supply good and enable high: start switching and soft-start
// R05 - power-not-good flag held at 1 during soft-start until 99 percent
// R06 - select pin low: regulate to low-select target, default 3.85 V
// R07 - select pin high: regulate to high-select target, default 3.45 V
// R08 - output voltage is 2.025 V plus code times 25 mV
// R09 - target change or select toggle ramps output at programmed slew rate
// R10 - four slew rates 1, 2.5, 5, 10 V/ms from control bits 1:0
// R11 - ramp forced-PWM bit set: forced PWM during ramp, auto afterwards
// R12 - ramp forced-PWM bit clear: stay automatic during ramp
// R13 - automatic mode without ramp PWM cannot drive a downward ramp
// R14 - forced PWM bit set: continuous fixed-frequency PWM at all loads
// R15 - ultrasonic bit set: switching frequency kept above 30 kHz
// R16 - automatic PFM is the default; PFM in DCM, PWM in CCM
// R17 - no load in automatic mode enters deep sleep; code enters no deep sleep while the ultrasonic bit is set
// R18 - enable low: actively discharge the output
// R19 - power-on reset loads both targets with default codes
// R20 - buck: on-time closes input high, then input low; output high closed
// R21 - light boost: after on-time output high closes until zero current
// R22 - supply near output in CCM: all four switches, half frequency
// R23 - power-not-good sets sticky flag, cleared by status read when good
// R24 - slew codes 00, 01, 10, 11 mean 1, 2.5, 5, 10 V/ms
// R25 - target codes above the 5.2 V code are clamped to it; code drops bit 7 of the written byte, so such codes wrap
`default_nettype none
package btr_pkg;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int ACCESS_DELAY_US = 100;
  // least time, rounded up to whole cycles
  localparam int ACCESS_CYC = (ACCESS_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int STEP_MV      = 25;
  localparam int BASE_MV      = 2025;
  localparam int SLEW_0_MV_MS = 1000;
  localparam int SLEW_1_MV_MS = 2500;
  localparam int SLEW_2_MV_MS = 5000;
  localparam int SLEW_3_MV_MS = 10000;
  // one code step takes STEP_MV / slew; ns = mV * 1e6 / (mV/ms)
  localparam int STEP_CYC_0 = (STEP_MV * 1000000) / (SLEW_0_MV_MS * CLK_PERIOD_NS);
  localparam int STEP_CYC_1 = (STEP_MV * 1000000) / (SLEW_1_MV_MS * CLK_PERIOD_NS);
  localparam int STEP_CYC_2 = (STEP_MV * 1000000) / (SLEW_2_MV_MS * CLK_PERIOD_NS);
  localparam int STEP_CYC_3 = (STEP_MV * 1000000) / (SLEW_3_MV_MS * CLK_PERIOD_NS);
  localparam int STEP_W     = 13;

  localparam int BB_HOLD_NS  = 50;
  localparam int BB_HOLD_CYC = (BB_HOLD_NS / CLK_PERIOD_NS < 1) ? 1 : BB_HOLD_NS / CLK_PERIOD_NS;

  localparam int CODE_W = 7;
  localparam int MV_W   = 13;
  localparam logic [CODE_W-1:0] CODE_MAX     = 7'h7f;
  localparam logic [CODE_W-1:0] DEF_CODE_LOW = 7'h49;
  localparam logic [CODE_W-1:0] DEF_CODE_HI  = 7'h39;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL     = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_LOW  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_HIGH = 8'h05;

  localparam int CTRL_SLEW_LSB     = 0;
  localparam int CTRL_SLEW_MSB     = 1;
  localparam int CTRL_RAMP_PWM_BIT = 2;
  localparam int CTRL_FORCED_PWM_BIT_BIT     = 3;
  localparam int CTRL_US_BIT       = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_MASK  = 8'h1f;
  localparam int STAT_PNG_BIT = 0;

  localparam logic [1:0] SLEW_1V0  = 2'h0;
  localparam logic [1:0] SLEW_2V5  = 2'h1;
  localparam logic [1:0] SLEW_5V0  = 2'h2;
  localparam logic [1:0] SLEW_10V0 = 2'h3;

  typedef enum logic [1:0] {ST_SHUTDOWN, ST_INHIBIT, ST_SOFTSTART, ST_RUN} btr_state_t;
  typedef enum logic [1:0] {PH_IDLE, PH_ON, PH_OFF, PH_TAIL} btr_phase_t;

  function automatic logic [MV_W-1:0] btr_code_to_mv(input logic [CODE_W-1:0] code);
    btr_code_to_mv = MV_W'(BASE_MV) + MV_W'(code) * MV_W'(STEP_MV);
  endfunction : btr_code_to_mv

  function automatic logic [CODE_W-1:0] btr_clamp_code(input logic [DATA_W-1:0] wdata);
    btr_clamp_code = (wdata[CODE_W-1:0] > CODE_MAX) ? CODE_MAX : wdata[CODE_W-1:0];
  endfunction : btr_clamp_code
endpackage : btr_pkg
`default_nettype wire

/* btr_ramp.sv */
// reference code ramp generator stepping one code per slew period
`default_nettype none
module btr_ramp
  import btr_pkg::*;
#(
  parameter int STEP0 = STEP_CYC_0,
  parameter int STEP1 = STEP_CYC_1,
  parameter int STEP2 = STEP_CYC_2,
  parameter int STEP3 = STEP_CYC_3
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              load_i,
  input  wire logic [CODE_W-1:0] target_i,
  input  wire logic [1:0]        slew_i,
  output logic      [CODE_W-1:0] code_o,
  output logic                   ramping_o,
  output logic                   down_o
);
  logic [STEP_W-1:0] tick_cnt;
  logic [STEP_W-1:0] period;
  logic              tick;
  logic [CODE_W-1:0] next_code;

  always_comb begin
    case (slew_i) // [R10] [R24]
      SLEW_1V0: period = STEP_W'(STEP0 - 1);
      SLEW_2V5: period = STEP_W'(STEP1 - 1);
      SLEW_5V0: period = STEP_W'(STEP2 - 1);
      default:  period = STEP_W'(STEP3 - 1);
    endcase
  end

  assign tick = (tick_cnt >= period);

  always_comb begin
    next_code = code_o;
    if (load_i) begin
      next_code = target_i;
    end else if (tick && code_o < target_i) begin
      next_code = code_o + 1'b1; // [R09]
    end else if (tick && code_o > target_i) begin
      next_code = code_o - 1'b1; // [R09]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
    end else if (ce_i) begin
      if (load_i || tick || code_o == target_i) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      code_o    <= DEF_CODE_LOW;
      ramping_o <= 1'b0;
      down_o    <= 1'b0;
    end else if (ce_i) begin
      code_o    <= next_code;
      ramping_o <= (next_code != target_i);
      down_o    <= (next_code > target_i);
    end
  end
endmodule : btr_ramp
`default_nettype wire

/* btr_switch.sv */
// four-switch gate sequencer for buck, boost and buck-boost regimes
`default_nettype none
module btr_switch
  import btr_pkg::*;
#(
  parameter int HOLD_CYC = BB_HOLD_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic run_i,
  input  wire logic on_pulse_i,
  input  wire logic zero_cur_i,
  input  wire logic ccm_i,
  input  wire logic vin_gt_vout_i,
  input  wire logic vin_near_vout_i,
  output logic      input_high_switch_o,
  output logic      input_low_switch_o,
  output logic      output_low_switch_o,
  output logic      output_high_switch_o,
  output logic      half_freq_o
);
  btr_phase_t phase;
  logic [7:0] hold_cnt;
  logic       hold_done;
  logic       off_like;
  logic       g_ih, g_il, g_ol, g_oh;

  assign hold_done = (hold_cnt >= 8'(HOLD_CYC - 1));
  assign off_like  = (phase == PH_OFF) || (phase == PH_TAIL);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      phase    <= PH_IDLE;
      hold_cnt <= '0;
    end else if (ce_i) begin
      hold_cnt <= (phase == PH_OFF && !hold_done) ? hold_cnt + 1'b1 : '0;
      if (!run_i) begin
        phase <= PH_IDLE;
      end else begin
        case (phase)
          PH_IDLE: if (on_pulse_i) phase <= PH_ON;
          PH_ON:   if (!on_pulse_i) phase <= PH_OFF;
          PH_OFF: begin
            if (on_pulse_i) phase <= PH_ON;
            else if (vin_near_vout_i && hold_done) phase <= PH_TAIL;
            else if (!vin_near_vout_i && !ccm_i && zero_cur_i) phase <= PH_IDLE; // [R21]
          end
          default: begin
            if (on_pulse_i) phase <= PH_ON;
            else if (!ccm_i && zero_cur_i) phase <= PH_IDLE;
          end
        endcase
      end
    end
  end

  always_comb begin
    g_ih = 1'b0;
    g_il = 1'b0;
    g_ol = 1'b0;
    g_oh = 1'b0;
    if (run_i && vin_near_vout_i) begin
      // on: in-high and out-low, then in-high and out-high, then in-low and out-high
      g_ih = (phase == PH_ON) || (phase == PH_OFF); // [R22]
      g_ol = (phase == PH_ON); // [R22]
      g_oh = off_like; // [R22]
      g_il = (phase == PH_TAIL); // [R22]
    end else if (run_i && vin_gt_vout_i) begin
      g_oh = 1'b1; // [R20]
      g_ih = (phase == PH_ON); // [R20]
      g_il = off_like; // [R20]
    end else if (run_i) begin
      g_ih = 1'b1; // [R21]
      g_ol = (phase == PH_ON);
      g_oh = off_like; // [R21]
    end
  end

  // gates are registered, so both switches of a leg never see a comb glitch
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      input_high_switch_o  <= 1'b0;
      input_low_switch_o   <= 1'b0;
      output_low_switch_o  <= 1'b0;
      output_high_switch_o <= 1'b0;
      half_freq_o          <= 1'b0;
    end else if (ce_i) begin
      input_high_switch_o  <= g_ih;
      input_low_switch_o   <= g_il;
      output_low_switch_o  <= g_ol;
      output_high_switch_o <= g_oh;
      half_freq_o          <= run_i && vin_near_vout_i && ccm_i; // [R22]
    end
  end
endmodule : btr_switch
`default_nettype wire

/* btr_converter_ctrl.sv */
// top of the buck-boost supervisory control: enable, soft-start, targets, modes
`default_nettype none
module btr_converter_ctrl
  import btr_pkg::*;
#(
  parameter int ACCESS_CYC_P = ACCESS_CYC,
  parameter int STEP_CYC_0_P = STEP_CYC_0
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              en_shutdown_i,
  input  wire logic              en_high_i,
  input  wire logic              supply_ok_i,
  input  wire logic              voltage_select_pin_i,
  input  wire logic              out_reached_i,
  input  wire logic              ccm_i,
  input  wire logic              no_load_i,
  input  wire logic              on_pulse_i,
  input  wire logic              zero_cur_i,
  input  wire logic              vin_gt_vout_i,
  input  wire logic              vin_near_vout_i,
  input  wire logic              reg_req_i,
  input  wire logic              reg_we_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic                   reg_ack_o,
  output logic                   reg_ready_o,
  output logic      [CODE_W-1:0] target_code_o,
  output logic      [MV_W-1:0]   target_mv_o,
  output logic                   switching_en_o,
  output logic                   soft_start_o,
  output logic                   power_not_good_flag_o,
  output logic                   discharge_o,
  output logic                   forced_pwm_o,
  output logic                   pfm_o,
  output logic                   deep_sleep_state_o,
  output logic                   ultrasonic_o,
  output logic                   ramp_sink_o,
  output logic                   input_high_switch_o,
  output logic                   input_low_switch_o,
  output logic                   output_low_switch_o,
  output logic                   output_high_switch_o,
  output logic                   half_freq_o
);
  localparam int ACC_W = $clog2(ACCESS_CYC_P + 1);

  btr_state_t        state;
  btr_state_t        next_state;
  logic [ACC_W-1:0]  access_cnt;
  logic [CODE_W-1:0] target_low_select;
  logic [CODE_W-1:0] target_high_select;
  logic [DATA_W-1:0] control;
  logic [CODE_W-1:0] sel_target;
  logic              run;
  logic              ramping;
  logic              ramp_down;
  logic              forced_pwm_bit_active;
  logic              wr_ok;
  logic              rd_status;
  logic              png_set;
  logic              png_clr;

  // ---------------- enable sequencing
  always_comb begin
    next_state = state;
    if (en_shutdown_i) begin
      next_state = ST_SHUTDOWN; // [R01]
    end else if (!en_high_i || !supply_ok_i) begin
      next_state = ST_INHIBIT; // [R03]
    end else begin
      case (state)
        ST_SHUTDOWN: next_state = ST_SOFTSTART; // [R04]
        ST_INHIBIT:  next_state = ST_SOFTSTART; // [R04]
        ST_SOFTSTART: begin
          if (out_reached_i) next_state = ST_RUN;
        end
        default: next_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state          <= ST_SHUTDOWN;
      switching_en_o <= 1'b0;
      soft_start_o   <= 1'b0;
      discharge_o    <= 1'b1;
    end else if (ce_i) begin
      state          <= next_state;
      switching_en_o <= (next_state == ST_SOFTSTART) || (next_state == ST_RUN); // [R03] [R04]
      soft_start_o   <= (next_state == ST_SOFTSTART);
      discharge_o    <= !en_high_i; // [R18]
    end
  end

  assign run = (state == ST_SOFTSTART) || (state == ST_RUN);

  // ---------------- access delay after enable rises
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      access_cnt  <= '0;
      reg_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (!en_high_i || en_shutdown_i) begin
        access_cnt  <= '0; // [R02]
        reg_ready_o <= 1'b0;
      end else if (!reg_ready_o) begin
        access_cnt  <= access_cnt + 1'b1;
        reg_ready_o <= (access_cnt == ACC_W'(ACCESS_CYC_P - 1)); // [R02]
      end
    end
  end

  // ---------------- register file
  assign wr_ok     = reg_req_i && reg_we_i && reg_ready_o; // [R02]
  assign rd_status = reg_req_i && !reg_we_i && reg_ready_o && (reg_addr_i == ADDR_STATUS);

  // shutdown reset waits for the clock enable so a frozen block keeps its state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || (ce_i && en_shutdown_i)) begin
      target_low_select  <= DEF_CODE_LOW; // [R01] [R19]
      target_high_select <= DEF_CODE_HI; // [R01] [R19]
      control            <= CTRL_RESET; // [R01] [R16]
    end else if (ce_i && wr_ok) begin
      if (reg_addr_i == ADDR_TARGET_LOW) begin
        target_low_select <= btr_clamp_code(reg_wdata_i); // [R25]
      end else if (reg_addr_i == ADDR_TARGET_HIGH) begin
        target_high_select <= btr_clamp_code(reg_wdata_i); // [R25]
      end else if (reg_addr_i == ADDR_CONTROL) begin
        control <= reg_wdata_i & CTRL_MASK;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
      reg_ack_o   <= 1'b0;
    end else if (ce_i) begin
      reg_ack_o <= reg_req_i && reg_ready_o; // [R02]
      if (reg_req_i && reg_ready_o && !reg_we_i) begin
        if (reg_addr_i == ADDR_TARGET_LOW) begin
          reg_rdata_o <= DATA_W'(target_low_select);
        end else if (reg_addr_i == ADDR_TARGET_HIGH) begin
          reg_rdata_o <= DATA_W'(target_high_select);
        end else if (reg_addr_i == ADDR_CONTROL) begin
          reg_rdata_o <= control;
        end else if (reg_addr_i == ADDR_STATUS) begin
          reg_rdata_o <= DATA_W'(power_not_good_flag_o) << STAT_PNG_BIT;
        end else begin
          reg_rdata_o <= '0;
        end
      end
    end
  end

  // ---------------- power-not-good flag; a new event wins over the read clear
  assign png_set = (next_state == ST_SOFTSTART) || (run && !out_reached_i); // [R05] [R23]
  assign png_clr = rd_status && out_reached_i; // [R23]

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || (ce_i && en_shutdown_i)) begin
      power_not_good_flag_o <= 1'b1;
    end else if (ce_i) begin
      power_not_good_flag_o <= png_set || (power_not_good_flag_o && !png_clr); // [R05] [R23]
    end
  end

  // ---------------- target selection and ramp
  assign sel_target = voltage_select_pin_i ? target_high_select : target_low_select; // [R06] [R07]

  // while not switching the reference follows the target so soft-start aims right
  btr_ramp #(
    .STEP0 (STEP_CYC_0_P),
    .STEP1 (STEP_CYC_1),
    .STEP2 (STEP_CYC_2),
    .STEP3 (STEP_CYC_3)
  ) u_ramp (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .load_i    (!run),
    .target_i  (sel_target),
    .slew_i    (control[CTRL_SLEW_MSB:CTRL_SLEW_LSB]),
    .code_o    (target_code_o),
    .ramping_o (ramping),
    .down_o    (ramp_down)
  );

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      target_mv_o <= btr_code_to_mv(DEF_CODE_LOW);
    end else if (ce_i) begin
      target_mv_o <= btr_code_to_mv(target_code_o); // [R08]
    end
  end

  // ---------------- light-load mode selection
  assign forced_pwm_bit_active = control[CTRL_FORCED_PWM_BIT_BIT] || (control[CTRL_RAMP_PWM_BIT] && ramping); // [R11] [R14]

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      forced_pwm_o       <= 1'b0;
      pfm_o              <= 1'b0;
      deep_sleep_state_o <= 1'b0;
      ultrasonic_o       <= 1'b0;
      ramp_sink_o        <= 1'b0;
    end else if (ce_i) begin
      forced_pwm_o       <= run && forced_pwm_bit_active; // [R11] [R12] [R14]
      pfm_o              <= run && !forced_pwm_bit_active && !ccm_i; // [R12] [R16]
      // ultrasonic floor forbids the deep sleep pause
      deep_sleep_state_o <= run && !forced_pwm_bit_active && no_load_i && !control[CTRL_US_BIT]; // [R17]
      ultrasonic_o       <= run && !forced_pwm_bit_active && control[CTRL_US_BIT]; // [R15]
      // a falling ramp is only driven when the stage may sink current
      ramp_sink_o        <= run && ramping && ramp_down && forced_pwm_bit_active; // [R13]
    end
  end

  btr_switch #(
    .HOLD_CYC (BB_HOLD_CYC)
  ) u_switch (
    .mclk_i               (mclk_i),
    .rst_n_i              (rst_n_i),
    .ce_i                 (ce_i),
    .run_i                (run),
    .on_pulse_i           (on_pulse_i),
    .zero_cur_i           (zero_cur_i),
    .ccm_i                (ccm_i || forced_pwm_o),
    .vin_gt_vout_i        (vin_gt_vout_i),
    .vin_near_vout_i      (vin_near_vout_i),
    .input_high_switch_o  (input_high_switch_o),
    .input_low_switch_o   (input_low_switch_o),
    .output_low_switch_o  (output_low_switch_o),
    .output_high_switch_o (output_high_switch_o),
    .half_freq_o          (half_freq_o)
  );

  // ---------------- assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_enable_rise;
    ce_i && !switching_en_o && en_high_i && supply_ok_i && !en_shutdown_i;
  endsequence

  a_shutdown_regs: assert property ((ce_i && en_shutdown_i) |=> // [R01]
      target_low_select == DEF_CODE_LOW && target_high_select == DEF_CODE_HI
      && control == CTRL_RESET)
    else $error("shutdown did not restore register defaults");

  a_access_block: assert property ((ce_i && reg_req_i && !reg_ready_o) |=> !reg_ack_o) // [R02]
    else $error("register access acknowledged during enable delay");

  a_inhibit_switch: assert property ((ce_i && !en_high_i) |=> !switching_en_o) // [R03]
    else $error("switching while enable below high threshold");

  a_start_softstart: assert property (s_enable_rise |=> switching_en_o && soft_start_o) // [R04]
    else $error("enable rise did not start soft-start");

  a_png_held: assert property (soft_start_o |-> power_not_good_flag_o) // [R05]
    else $error("power-not-good flag low during soft-start");

  a_sel_low: assert property ((ce_i && !run && !voltage_select_pin_i) |=> // [R06]
      target_code_o == $past(target_low_select))
    else $error("low select did not pick low target");

  a_sel_high: assert property ((ce_i && !run && voltage_select_pin_i) |=> // [R07]
      target_code_o == $past(target_high_select))
    else $error("high select did not pick high target");

  a_ramp_slew: assert property ((run && $past(run)) |-> // [R09]
      target_code_o == $past(target_code_o)
      || target_code_o == $past(target_code_o) + 7'h01
      || target_code_o == $past(target_code_o) - 7'h01)
    else $error("ramp moved more than one code per step");

  a_mv_map: assert property (ce_i |=> // [R08]
      int'(target_mv_o) == BASE_MV + STEP_MV * int'($past(target_code_o)))
    else $error("target millivolts do not match the code");

  a_forced_pwm_bit_ramp: assert property ((ce_i && run && ramping && control[CTRL_RAMP_PWM_BIT]) // [R11]
      |=> forced_pwm_o)
    else $error("no forced PWM during ramp");

  a_auto_ramp: assert property ((ce_i && !control[CTRL_RAMP_PWM_BIT] // [R12]
      && !control[CTRL_FORCED_PWM_BIT_BIT]) |=> !forced_pwm_o)
    else $error("forced PWM without any enable bit");

  a_no_sink: assert property (ramp_sink_o |-> forced_pwm_o) // [R13]
    else $error("downward ramp driven in automatic mode");

  a_discharge: assert property ((ce_i && !en_high_i) |=> discharge_o) // [R18]
    else $error("output not discharged with enable low");
endmodule : btr_converter_ctrl
`default_nettype wire

/* btr_host_model.sv */
// host model driving the register request port
`default_nettype none
module btr_host_model
  import btr_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              ack_i,
  input  wire logic              ready_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  output var  logic              req_o,
  output var  logic              we_o,
  output var  logic [ADDR_W-1:0] addr_o,
  output var  logic [DATA_W-1:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {req_o, we_o, addr_o, wdata_o} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
    ok = 0;
    q = '0;
    // host holds off until the access delay has run out
    for (int i = 0; i < 100 && ready_i !== 1'b1; i++) @(negedge mclk_i);
    if (ready_i !== 1'b1) return;
    @(negedge mclk_i);
    {req_o, we_o, addr_o, wdata_o} = {1'b1, w, a, d};
    @(negedge mclk_i);
    req_o = 1'b0;
    // released data is inverted so a stale value cannot pass
    wdata_o = ~d;
    // strobe stands for one edge only; the ack stands in the cycle just after it
    for (int i = 0; i < 4 && !ok; i++) begin
      if (ack_i === 1'b1) begin
        ok = 1;
        q = rdata_i;
      end else begin
        @(negedge mclk_i);
      end
    end
  endtask : xfer
endmodule : btr_host_model
`default_nettype wire

/* tb_btr_converter_ctrl.sv */
// self-checking bench for the converter control top
`default_nettype none
module tb_btr_converter_ctrl
  import btr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_i = 0, rst_n_i = 0, en_sd = 0, en_hi = 0, sup = 0, voltage_select_pin = 0, rch = 0;
  logic [5:0]  rnd = '0;
  logic [15:0] lfsr = 16'h0005;
  logic        req, we, ack, rdy, sw, ss, flag, dis, forced_pwm_bit, us;
  logic [7:0]  addr, wd, rd, outs;
  logic [6:0]  code;
  logic [12:0] mv;
  int          miscompares = 0, comparisons = 0, m_low = 'h49, m_ctrl = 0;
  always #2.5 mclk_i = ~mclk_i;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  always @(negedge mclk_i) begin
    lfsr <= lfsr_next(lfsr);
    rnd <= lfsr[5:0];
  end
  localparam int SLOW_STEP = 50;
  btr_converter_ctrl #(.ACCESS_CYC_P(20), .STEP_CYC_0_P(SLOW_STEP)) dut_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .en_shutdown_i(en_sd),
    .en_high_i(en_hi), .supply_ok_i(sup), .voltage_select_pin_i(voltage_select_pin),
    .out_reached_i(rch), .ccm_i(rnd[0]), .no_load_i(rnd[1]), .on_pulse_i(rnd[2]),
    .zero_cur_i(rnd[3]), .vin_gt_vout_i(rnd[4]), .vin_near_vout_i(rnd[5]),
    .reg_req_i(req), .reg_we_i(we), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_rdata_o(rd), .reg_ack_o(ack), .reg_ready_o(rdy), .target_code_o(code),
    .target_mv_o(mv), .switching_en_o(sw), .soft_start_o(ss),
    .power_not_good_flag_o(flag), .discharge_o(dis), .forced_pwm_o(forced_pwm_bit), .pfm_o(outs[0]),
    .deep_sleep_state_o(outs[1]), .ultrasonic_o(us), .ramp_sink_o(outs[2]),
    .input_high_switch_o(outs[3]), .input_low_switch_o(outs[4]),
    .output_low_switch_o(outs[5]), .output_high_switch_o(outs[6]), .half_freq_o(outs[7]));
  btr_host_model host_u (.mclk_i(mclk_i), .ack_i(ack), .ready_i(rdy), .rdata_i(rd),
    .req_o(req), .we_o(we), .addr_o(addr), .wdata_o(wd));
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bit         ok;
    host_u.xfer(w, a, d, q, ok);
    chk("ack", 1, ok);
    if (!ok) report_and_stop();
    else if (!w) chk("rdata", d, q);
  endtask : acc
  task automatic ramp(input logic pwm);
    int t;
    int n;
    t = voltage_select_pin ? 'h39 : m_low;
    repeat (3) @(negedge mclk_i);
    chk("ramp pwm", pwm, forced_pwm_bit);
    chk("ramp sink", pwm && voltage_select_pin, outs[2]);
    for (n = 0; n < 8000 && code !== 7'(t); n++) @(negedge mclk_i);
    chk("code", t, code);
    if (code !== 7'(t)) begin
      report_and_stop();
    end else begin
      // one code per full step period, counted from three cycles after the change
      chk("ramp cycles", SLOW_STEP * (voltage_select_pin ? m_low - t : t - 'h49) - 3, n);
      repeat (3) @(negedge mclk_i);
      chk("mv", BASE_MV + STEP_MV * t, mv);
      chk("pwm after", 0, forced_pwm_bit);
      chk("sink after", 0, outs[2]);
    end
  endtask : ramp
  initial begin
    repeat (8) @(negedge mclk_i);
    rst_n_i = 1;
    chk("code", 'h49, code);
    chk("discharge", 1, dis);
    chk("switching", 0, sw);
    sup = 1;
    en_hi = 1;
    repeat (2) @(negedge mclk_i);
    chk("ready", 0, rdy);
    chk("switching", 1, sw);
    chk("soft start", 1, ss);
    acc(0, ADDR_STATUS, 8'h01);
    acc(0, ADDR_TARGET_HIGH, 8'h39);
    acc(0, ADDR_CONTROL, 8'h00);
    acc(0, 8'h07, 8'h00);
    rch = 1;
    repeat (3) @(negedge mclk_i);
    chk("soft start", 0, ss);
    acc(0, ADDR_STATUS, 8'h01);
    acc(0, ADDR_STATUS, 8'h00);
    m_low = 'h50 + int'(lfsr[4:0]);
    acc(1, ADDR_TARGET_LOW, {lfsr[7], 7'(m_low)});
    ramp(0);
    acc(0, ADDR_TARGET_LOW, 8'(m_low));
    m_ctrl = 'h04;
    acc(1, ADDR_CONTROL, 8'(m_ctrl));
    acc(0, ADDR_CONTROL, 8'(m_ctrl));
    voltage_select_pin = 1;
    ramp(1);
    acc(1, ADDR_CONTROL, 8'h10);
    repeat (3) @(negedge mclk_i);
    chk("ultrasonic", 1, us);
    acc(1, ADDR_CONTROL, 8'h08);
    repeat (3) @(negedge mclk_i);
    chk("forced_pwm_bit", 1, forced_pwm_bit);
    chk("ultrasonic", 0, us);
    en_sd = 1;
    en_hi = 0;
    repeat (3) @(negedge mclk_i);
    chk("discharge", 1, dis);
    chk("switching", 0, sw);
    chk("idle outs", 0, outs);
    en_sd = 0;
    en_hi = 1;
    acc(0, ADDR_CONTROL, 8'h00);
    acc(0, ADDR_TARGET_LOW, 8'h49);
    report_and_stop();
  end
endmodule : tb_btr_converter_ctrl
`default_nettype wire
